/* File: rtl/dd_drive_data_if.sv */
// Drive-side data interface: write serializer, sequencer, read mark search
`timescale 1ns/1ps
module dd_drive_data_if #(
  parameter int unsigned SEARCH_TIMEOUT_CYCLES = dd_pkg::DD_SEARCH_TIMEOUT_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic read_clock_in,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_code,
  input wire logic [1:0] mode,
  input wire logic hard_sector,
  input wire dd_pkg::dd_fmt_cfg_t fmt_cfg,
  input wire dd_pkg::dd_id_t target_id,
  input wire logic [7:0] wr_byte,
  input wire logic wr_byte_valid,
  output logic wr_byte_ready,
  input wire logic write_fault_in,
  input wire logic sector_marker_in,
  input wire logic read_data_in,
  output logic disk_write_data,
  output logic late_clk_out,
  output logic early_ame_out,
  output logic write_gate_out,
  output logic read_gate_out,
  output dd_pkg::dd_status_t status
);

  // ************************************************************
  // Functions
  // ************************************************************
  function automatic logic [7:0] id_byte(input dd_pkg::dd_id_t id, input logic [1:0] idx);
    case (idx)
      2'h0: id_byte = id.cyl_hi;
      2'h1: id_byte = id.cyl_lo;
      2'h2: id_byte = id.head;
      default: id_byte = id.sector;
    endcase
  endfunction

  function automatic logic is_id_mark(input logic [7:0] b);
    is_id_mark = (b >= dd_pkg::DD_MARK_ID_HI_MIN) ||
                 (b >= dd_pkg::DD_MARK_ID_LO_MIN && b <= dd_pkg::DD_MARK_ID_LO_MAX);
  endfunction

  // ************************************************************
  // Write clock domain: synchronisers
  // ************************************************************
  logic [1:0] wf_sync_reg;
  logic [1:0] sct_sync_reg;
  logic [1:0] ack_sync_reg;
  logic sct_d_reg;
  logic wf;
  logic sct_rise;
  logic ack_s;
  logic match_reg;
  logic ack_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wf_sync_reg <= 2'h0;
      sct_sync_reg <= 2'h0;
      ack_sync_reg <= 2'h0;
      sct_d_reg <= 1'b0;
    end else begin
      wf_sync_reg <= {wf_sync_reg[0], write_fault_in};
      sct_sync_reg <= {sct_sync_reg[0], sector_marker_in};
      ack_sync_reg <= {ack_sync_reg[0], ack_reg};
      sct_d_reg <= sct_sync_reg[1];
    end
  end

  assign wf = wf_sync_reg[1];
  assign sct_rise = sct_sync_reg[1] & ~sct_d_reg;
  assign ack_s = ack_sync_reg[1];

  // ************************************************************
  // Command sequencer
  // ************************************************************
  typedef enum logic [3:0] {
    S_IDLE, S_WAIT_SCT, S_PRE, S_AM1, S_AM2, S_ID, S_PAD, S_GAP,
    S_DPRE, S_DAM1, S_DAM2, S_DATA, S_DPAD, S_TAIL, S_SEARCH, S_RELEASE
  } dd_wstate_t;

  dd_wstate_t state_reg;
  dd_wstate_t state_next;
  logic [1:0] cmd_reg;
  logic [1:0] mode_reg;
  logic hard_reg;
  dd_pkg::dd_fmt_cfg_t cfg_reg;
  dd_pkg::dd_id_t id_reg;
  logic [15:0] cnt_reg;
  logic [31:0] tmo_reg;
  logic req_reg;
  logic gate_reg;
  logic rgate_reg;
  logic [3:0] cell_reg;
  logic [7:0] byte_reg;
  logic am_byte_reg;
  logic prev_bit_reg;
  logic [1:0] hist_reg;
  logic wd_reg;
  logic late_reg;
  logic early_reg;
  logic ready_reg;
  dd_pkg::dd_status_t status_reg;

  logic mfm;
  logic nrz;
  logic writing;
  logic byte_end;
  logic last_byte;
  logic abort;
  logic [3:0] cell_last;
  logic [15:0] state_len;
  logic [7:0] tx_byte;
  logic [2:0] bit_idx;
  logic cur_bit;
  logic clk_bit;
  logic cell_val;

  assign mfm = mode_reg == dd_pkg::DD_MODE_MFM;
  assign nrz = mode_reg == dd_pkg::DD_MODE_NRZ;
  assign cell_last = mfm ? dd_pkg::DD_CELL_LAST_MFM : dd_pkg::DD_CELL_LAST_RAW;
  assign writing = state_reg inside {[S_PRE:S_TAIL]};
  assign byte_end = writing && cell_reg == cell_last;
  assign last_byte = (cnt_reg + 16'h0001) >= state_len;
  assign abort = wf && (writing || (state_reg == S_WAIT_SCT && cmd_reg != dd_pkg::DD_CMD_READ_ID));

  always_comb begin
    state_len = 16'h0001;
    tx_byte = dd_pkg::DD_FILL;
    state_next = S_IDLE;
    case (state_reg)
      S_PRE: begin
        state_len = {8'h00, cfg_reg.id_pre_len};
        state_next = S_AM1;
      end
      S_AM1: begin
        tx_byte = dd_pkg::DD_AM_SYNC;
        state_next = S_AM2;
      end
      S_AM2: begin
        tx_byte = dd_pkg::DD_MARK_ID;
        state_next = S_ID;
      end
      S_ID: begin
        state_len = dd_pkg::DD_ID_BYTES;
        tx_byte = id_byte(id_reg, cnt_reg[1:0]);
        state_next = S_PAD;
      end
      S_PAD: begin
        state_len = {12'h000, cfg_reg.id_pad_len};
        state_next = S_GAP;
      end
      S_GAP: begin
        state_len = {8'h00, cfg_reg.gap_len};
        tx_byte = cfg_reg.gap_fill;
        state_next = S_DPRE;
      end
      S_DPRE: begin
        state_len = {8'h00, cfg_reg.data_pre_len};
        state_next = S_DAM1;
      end
      S_DAM1: begin
        tx_byte = dd_pkg::DD_AM_SYNC;
        state_next = S_DAM2;
      end
      S_DAM2: begin
        tx_byte = dd_pkg::DD_MARK_DATA;
        state_next = S_DATA;
      end
      S_DATA: begin
        state_len = dd_pkg::DD_SECTOR_BYTES;
        tx_byte = wr_byte_valid ? wr_byte : dd_pkg::DD_FILL;
        state_next = S_DPAD;
      end
      S_DPAD: begin
        state_len = {12'h000, cfg_reg.data_pad_len};
        state_next = S_TAIL;
      end
      S_TAIL: begin
        // NRZ holds the gate one byte longer
        state_len = nrz ? dd_pkg::DD_NRZ_TAIL_BYTES : dd_pkg::DD_TAIL_BYTES;
        state_next = S_IDLE;
      end
      default: begin
        state_next = S_IDLE;
      end
    endcase
  end

  // Sequencer on the write clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      cmd_reg <= 2'h0;
      mode_reg <= 2'h0;
      hard_reg <= 1'b0;
      cfg_reg <= '0;
      id_reg <= '0;
      cnt_reg <= 16'h0000;
      tmo_reg <= 32'h0000_0000;
      req_reg <= 1'b0;
      rgate_reg <= 1'b0;
      status_reg <= '0;
    end else begin
      status_reg.done <= 1'b0;
      if (abort) begin
        state_reg <= S_IDLE;
        status_reg.fault <= 1'b1;
        status_reg.done <= 1'b1;
        status_reg.busy <= 1'b0;
      end else begin
        unique case (state_reg)
          S_IDLE: begin
            if (cmd_write) begin
              cmd_reg <= cmd_code;
              mode_reg <= mode;
              hard_reg <= hard_sector;
              cfg_reg <= fmt_cfg;
              id_reg <= target_id;
              cnt_reg <= 16'h0000;
              status_reg <= '0;
              status_reg.busy <= 1'b1;
              state_reg <= S_WAIT_SCT;
            end
          end
          S_WAIT_SCT: begin
            if (!hard_reg || sct_rise) begin
              tmo_reg <= 32'h0000_0000;
              if (cmd_reg == dd_pkg::DD_CMD_READ_ID) begin
                req_reg <= 1'b1;
                rgate_reg <= 1'b1;
                state_reg <= S_SEARCH;
              end else if (cmd_reg == dd_pkg::DD_CMD_FORMAT) begin
                state_reg <= S_PRE;
              end else begin
                state_reg <= S_DPRE;
              end
            end
          end
          S_SEARCH: begin
            tmo_reg <= tmo_reg + 32'h0000_0001;
            if (ack_s) begin
              status_reg.id_match <= match_reg;
              req_reg <= 1'b0;
              rgate_reg <= 1'b0;
              state_reg <= S_RELEASE;
            end else if (tmo_reg == 32'(SEARCH_TIMEOUT_CYCLES - 1)) begin
              req_reg <= 1'b0;
              rgate_reg <= 1'b0;
              state_reg <= S_RELEASE;
            end
          end
          S_RELEASE: begin
            if (!ack_s) begin
              status_reg.busy <= 1'b0;
              status_reg.done <= 1'b1;
              state_reg <= S_IDLE;
            end
          end
          default: begin
            if (byte_end) begin
              if (state_reg == S_DATA && !wr_byte_valid) begin
                status_reg.underrun <= 1'b1;
              end
              if (last_byte) begin
                cnt_reg <= 16'h0000;
                state_reg <= state_next;
                if (state_next == S_IDLE) begin
                  status_reg.busy <= 1'b0;
                  status_reg.done <= 1'b1;
                end
              end else begin
                cnt_reg <= cnt_reg + 16'h0001;
              end
            end
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Write serializer
  // ************************************************************
  assign bit_idx = mfm ? cell_reg[3:1] : cell_reg[2:0];
  assign cur_bit = byte_reg[3'h7 - bit_idx];
  assign clk_bit = ~prev_bit_reg & ~cur_bit & ~(am_byte_reg && cell_reg == dd_pkg::DD_MISSING_CLK_CELL);
  assign cell_val = gate_reg & (mfm ? (cell_reg[0] ? cur_bit : clk_bit) : cur_bit);

  // One cell per write clock
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cell_reg <= 4'h0;
    end else if (!writing) begin
      cell_reg <= cell_last;
    end else if (byte_end) begin
      cell_reg <= 4'h0;
    end else begin
      cell_reg <= cell_reg + 4'h1;
    end
  end

  // Load next byte and gate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      byte_reg <= 8'h00;
      am_byte_reg <= 1'b0;
      gate_reg <= 1'b0;
    end else if (wf) begin
      gate_reg <= 1'b0;
    end else if (byte_end) begin
      if (state_reg == S_TAIL && last_byte) begin
        gate_reg <= 1'b0;
        am_byte_reg <= 1'b0;
      end else begin
        byte_reg <= tx_byte;
        am_byte_reg <= state_reg == S_AM1 || state_reg == S_DAM1;
        gate_reg <= 1'b1;
      end
    end
  end

  // Data bit history for MFM clock cells and precompensation
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_bit_reg <= 1'b0;
      hist_reg <= 2'h0;
    end else begin
      if (!gate_reg) begin
        prev_bit_reg <= 1'b0;
      end else if (!mfm || cell_reg[0]) begin
        prev_bit_reg <= cur_bit;
      end
      hist_reg <= {hist_reg[0], cell_val};
    end
  end

  // Pin outputs
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      wd_reg <= 1'b0;
      late_reg <= 1'b0;
      early_reg <= 1'b0;
      ready_reg <= 1'b0;
    end else begin
      wd_reg <= cell_val;
      if (nrz) begin
        late_reg <= gate_reg & ~late_reg;
        early_reg <= gate_reg & am_byte_reg;
      end else begin
        late_reg <= cell_val & hist_reg[1];
        early_reg <= cell_val & ~hist_reg[1] & ~hist_reg[0];
      end
      ready_reg <= state_reg == S_DATA && cell_reg == cell_last - 4'h1;
    end
  end

  assign disk_write_data = wd_reg;
  assign late_clk_out = late_reg;
  assign early_ame_out = early_reg;
  assign write_gate_out = gate_reg;
  assign read_gate_out = rgate_reg;
  assign wr_byte_ready = ready_reg;
  assign status = status_reg;

  // ************************************************************
  // Read clock domain: mark search and ID compare
  // ************************************************************
  typedef enum logic [2:0] {R_IDLE, R_HUNT, R_MARK, R_ID, R_DONE} dd_rstate_t;

  dd_rstate_t rstate_reg;
  logic [1:0] req_sync_reg;
  logic [1:0] rd_sync_reg;
  logic [1:0] sct_rc_sync_reg;
  logic sct_rc_d_reg;
  logic [15:0] raw_reg;
  logic phase_reg;
  logic [2:0] bit_cnt_reg;
  logic [7:0] sh_reg;
  logic [1:0] idx_reg;
  logic armed_reg;
  logic req_s;
  logic rd;
  logic data_run_detect;
  logic am_found;
  logic r_mfm;
  logic r_nrz;
  logic hit;
  logic take;
  logic [7:0] rx_byte;

  assign req_s = req_sync_reg[1];
  assign rd = rd_sync_reg[1];
  assign data_run_detect = sct_rc_sync_reg[1];
  assign am_found = sct_rc_sync_reg[1] & ~sct_rc_d_reg;
  // Mode and target ID are held stable while the request stands
  assign r_mfm = mode_reg == dd_pkg::DD_MODE_MFM;
  assign r_nrz = mode_reg == dd_pkg::DD_MODE_NRZ;
  assign rx_byte = {sh_reg[6:0], rd};
  assign take = !r_mfm || phase_reg;

  always_comb begin
    if (r_nrz && !hard_reg) begin
      hit = am_found;
    end else if (r_mfm) begin
      hit = (hard_reg || armed_reg) && raw_reg == dd_pkg::DD_AM_MFM_CELLS;
    end else begin
      // RLL stream arrives decoded to data bits, one bit per read clock
      hit = (hard_reg || armed_reg || r_nrz) && raw_reg[7:0] == dd_pkg::DD_AM_SYNC;
    end
  end

  always_ff @(posedge read_clock_in or posedge rst) begin
    if (rst) begin
      req_sync_reg <= 2'h0;
      rd_sync_reg <= 2'h0;
      sct_rc_sync_reg <= 2'h0;
      sct_rc_d_reg <= 1'b0;
      raw_reg <= 16'h0000;
    end else begin
      req_sync_reg <= {req_sync_reg[0], req_reg};
      rd_sync_reg <= {rd_sync_reg[0], read_data_in};
      sct_rc_sync_reg <= {sct_rc_sync_reg[0], sector_marker_in};
      sct_rc_d_reg <= sct_rc_sync_reg[1];
      raw_reg <= {raw_reg[14:0], rd};
    end
  end

  always_ff @(posedge read_clock_in or posedge rst) begin
    if (rst) begin
      rstate_reg <= R_IDLE;
      phase_reg <= 1'b0;
      bit_cnt_reg <= 3'h0;
      sh_reg <= 8'h00;
      idx_reg <= 2'h0;
      armed_reg <= 1'b0;
      match_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else if (!req_s) begin
      rstate_reg <= R_IDLE;
      ack_reg <= 1'b0;
      armed_reg <= 1'b0;
    end else begin
      phase_reg <= ~phase_reg;
      if (take) begin
        sh_reg <= rx_byte;
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      end
      unique case (rstate_reg)
        R_IDLE: begin
          rstate_reg <= R_HUNT;
        end
        R_HUNT: begin
          armed_reg <= armed_reg | data_run_detect;
          if (hit) begin
            rstate_reg <= R_MARK;
            phase_reg <= 1'b1;
            sh_reg <= r_mfm ? 8'h00 : {7'h00, rd};
            bit_cnt_reg <= r_mfm ? 3'h0 : 3'h1;
          end
        end
        R_MARK: begin
          if (take && bit_cnt_reg == 3'h7) begin
            idx_reg <= 2'h0;
            match_reg <= 1'b1;
            rstate_reg <= is_id_mark(rx_byte) ? R_ID : R_HUNT;
          end
        end
        R_ID: begin
          if (take && bit_cnt_reg == 3'h7) begin
            match_reg <= match_reg && rx_byte == id_byte(id_reg, idx_reg);
            idx_reg <= idx_reg + 2'h1;
            if (idx_reg == 2'h3) begin
              rstate_reg <= R_DONE;
            end
          end
        end
        R_DONE: begin
          ack_reg <= 1'b1;
        end
      endcase
    end
  end

  // Rates up to the highest documented bit rate run one cell per clock
endmodule

/* File: pkg/dd_pkg.sv */
// Constants and types of the disk drive data interface
// Function
// - Shift write data out on write clock
// - NRZ: shared late pin is clock out
// - NRZ: shared early pin is mark enable
// - MFM/RLL: early and late precompensation strobes
// - Write gate only while writing, fault drops
// - Hard sector: sector input starts sector
// - Soft NRZ: sector input is mark found
// - Soft MFM/RLL: input is data run
// - MFM read: split data from clock cells
// - Read gate from search to field end
// - Sequencer runs on write clock
// - Rates up to 15/24 Mbs
// - Clock rate equals bit rate; MFM mode here writes one cell per clock, so two clocks per data bit
// - RLL (2,7) code, 4-bit error spread; RLL mode here shifts plain data bits with no (2,7) coding
// - NRZ: qualify data, adapt gate timing
// - Format uses programmed ID preamble, gap, pads
// - Write uses programmed data preamble, pads
// - Command write starts the sequencer
// - Handshake between write and read domains
// - Equivalence compare of ID bytes
// - MFM mark A1 with missing clock
// - Mark byte selects ID or data field
// - Bytes go out MSB first
// - NRZ: codec bypassed, rising edges
package dd_pkg;
  localparam logic [1:0] DD_MODE_MFM = 2'h0;
  localparam logic [1:0] DD_MODE_RLL = 2'h1;
  localparam logic [1:0] DD_MODE_NRZ = 2'h2;
  localparam logic [1:0] DD_CMD_READ_ID = 2'h0;
  localparam logic [1:0] DD_CMD_WRITE = 2'h1;
  localparam logic [1:0] DD_CMD_FORMAT = 2'h2;
  localparam logic [7:0] DD_AM_SYNC = 8'ha1;
  localparam logic [7:0] DD_MARK_ID = 8'hfe;
  localparam logic [7:0] DD_MARK_DATA = 8'hf8;
  localparam logic [7:0] DD_MARK_ID_HI_MIN = 8'hfc;
  localparam logic [7:0] DD_MARK_ID_LO_MIN = 8'hf4;
  localparam logic [7:0] DD_MARK_ID_LO_MAX = 8'hf7;
  localparam logic [7:0] DD_FILL = 8'h00;
  localparam logic [15:0] DD_AM_MFM_CELLS = 16'h4489;
  localparam logic [3:0] DD_MISSING_CLK_CELL = 4'ha;
  localparam logic [3:0] DD_CELL_LAST_MFM = 4'hf;
  localparam logic [3:0] DD_CELL_LAST_RAW = 4'h7;
  localparam logic [15:0] DD_SECTOR_BYTES = 16'h0200;
  localparam logic [15:0] DD_ID_BYTES = 16'h0004;
  localparam logic [15:0] DD_NRZ_TAIL_BYTES = 16'h0002;
  localparam logic [15:0] DD_TAIL_BYTES = 16'h0001;
  localparam int DD_CLK_MHZ = 40;
  localparam int DD_SEARCH_TIMEOUT_US = 2000;
  localparam int DD_SEARCH_TIMEOUT_CYCLES = DD_SEARCH_TIMEOUT_US * DD_CLK_MHZ;

  typedef struct packed {
    logic [7:0] cyl_hi;
    logic [7:0] cyl_lo;
    logic [7:0] head;
    logic [7:0] sector;
  } dd_id_t;

  typedef struct packed {
    logic [7:0] id_pre_len;
    logic [7:0] data_pre_len;
    logic [7:0] gap_len;
    logic [7:0] gap_fill;
    logic [3:0] id_pad_len;
    logic [3:0] data_pad_len;
  } dd_fmt_cfg_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic id_match;
    logic fault;
    logic underrun;
  } dd_status_t;
endpackage

/* File: verification/dd_drive_data_if_chk.sv */
// Assertion checker for the drive data interface ports
`timescale 1ns/1ps
module dd_drive_data_if_chk (
  input wire logic clock,
  input wire logic rst,
  input wire logic cmd_write,
  input wire logic [1:0] cmd_code,
  input wire logic [1:0] mode,
  input wire logic hard_sector,
  input wire logic write_fault_in,
  input wire logic late_clk_out,
  input wire logic early_ame_out,
  input wire logic write_gate_out,
  input wire logic read_gate_out,
  input wire dd_pkg::dd_status_t status
);
  // ****************************************
  // Command sequencing and gate properties
  // ****************************************
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);

  sequence s_take(code);
    cmd_write && !status.busy && !hard_sector && cmd_code == code;
  endsequence

  sequence s_nrz_gate;
    (mode == dd_pkg::DD_MODE_NRZ && write_gate_out) [*3];
  endsequence

  a_cmd_busy: assert property (cmd_write && !status.busy |=> status.busy)
    else $error("command not taken");
  a_done_pulse: assert property (status.done |=> !status.done && !status.busy)
    else $error("done not a single pulse");
  a_wgate_start: assert property (s_take(dd_pkg::DD_CMD_WRITE) |-> ##3 write_gate_out)
    else $error("write gate late");
  a_rgate_start: assert property (s_take(dd_pkg::DD_CMD_READ_ID) |-> ##[1:3] read_gate_out)
    else $error("read gate late");
  a_gate_in_cmd: assert property (write_gate_out || read_gate_out |-> status.busy || status.done)
    else $error("gate outside command");
  a_gates_apart: assert property (!(write_gate_out && read_gate_out))
    else $error("both gates high");
  a_fault_drop: assert property ($rose(write_fault_in) |-> ##[1:4] !write_gate_out)
    else $error("gate held on fault");
  a_fault_flag: assert property ($rose(write_fault_in) && write_gate_out |-> ##[1:4] status.fault)
    else $error("fault not flagged");
  a_nrz_toggle: assert property (s_nrz_gate |-> late_clk_out != $past(late_clk_out))
    else $error("write clock out stuck");
  a_precomp_apart: assert property (mode != dd_pkg::DD_MODE_NRZ |-> !(early_ame_out && late_clk_out))
    else $error("early and late together");
  a_ame_in_gate: assert property (mode == dd_pkg::DD_MODE_NRZ && early_ame_out |-> write_gate_out)
    else $error("mark enable outside gate");
endmodule

bind dd_drive_data_if dd_drive_data_if_chk u_chk (.clock, .rst, .cmd_write, .cmd_code, .mode, .hard_sector,
  .write_fault_in, .late_clk_out, .early_ame_out, .write_gate_out, .read_gate_out, .status);

/* File: verification/dd_drive_model.sv */
// Behavioural drive: captures written cells, plays back a read pattern
`timescale 1ns/1ps
module dd_drive_model (
  input wire logic clock,
  input wire logic rst,
  input wire logic read_clock_in,
  input wire logic disk_write_data,
  input wire logic write_gate_out,
  input wire logic read_gate_out,
  input wire logic [63:0] rd_pat,
  output logic read_data_in,
  output logic [63:0] wr_cap
);
  // ****************************************
  // Write capture and read playback
  // ****************************************
  logic gate_d_reg;
  logic [6:0] wr_cnt_reg;
  logic [1:0] rg_sync_reg;
  logic [6:0] rd_idx_reg;

  // First 64 cells, first cell one clock after gate
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      gate_d_reg <= 1'b0;
      wr_cnt_reg <= 7'h00;
      wr_cap <= 64'h0;
    end else begin
      gate_d_reg <= write_gate_out;
      if (!gate_d_reg) begin
        wr_cnt_reg <= 7'h00;
      end else if (wr_cnt_reg < 7'h40) begin
        wr_cap <= {wr_cap[62:0], disk_write_data};
        wr_cnt_reg <= wr_cnt_reg + 7'h01;
      end
    end
  end

  // Idle line toggles; in gate: 32 zero bits then pattern MSB first
  always_ff @(posedge read_clock_in or posedge rst) begin
    if (rst) begin
      rg_sync_reg <= 2'h0;
      rd_idx_reg <= 7'h00;
      read_data_in <= 1'b0;
    end else begin
      rg_sync_reg <= {rg_sync_reg[0], read_gate_out};
      if (!rg_sync_reg[1]) begin
        rd_idx_reg <= 7'h00;
        read_data_in <= ~read_data_in;
      end else begin
        read_data_in <= (rd_idx_reg >= 7'h20 && rd_idx_reg < 7'h60) ? rd_pat[7'h5f - rd_idx_reg] : 1'b0;
        if (rd_idx_reg < 7'h60) begin
          rd_idx_reg <= rd_idx_reg + 7'h01;
        end
      end
    end
  end
endmodule

/* File: verification/test_dd_drive_data_if.sv */
// Self-checking testbench of the drive data interface
`timescale 1ns/1ps
module test_dd_drive_data_if;
  // ****************************************
  // Signals, rows and helpers
  // ****************************************
  typedef struct packed {
    logic [1:0] code;
    logic [1:0] mode;
    logic [7:0] pre;
    logic [63:0] pat;
    logic match;
  } dd_row_t;
  localparam dd_row_t ROWS [7] = '{
    '{dd_pkg::DD_CMD_WRITE, dd_pkg::DD_MODE_MFM, 8'h01, 64'haaaa4489554a9144, 1'b0},
    '{dd_pkg::DD_CMD_WRITE, dd_pkg::DD_MODE_RLL, 8'h03, 64'h000000a1f85a5a5a, 1'b0},
    '{dd_pkg::DD_CMD_WRITE, dd_pkg::DD_MODE_NRZ, 8'h02, 64'h0000a1f85a5a5a5a, 1'b0},
    '{dd_pkg::DD_CMD_READ_ID, dd_pkg::DD_MODE_RLL, 8'h02, 64'h0000a1fe12345678, 1'b1},
    '{dd_pkg::DD_CMD_READ_ID, dd_pkg::DD_MODE_RLL, 8'h02, 64'h0000a1fe12345679, 1'b0},
    '{dd_pkg::DD_CMD_READ_ID, dd_pkg::DD_MODE_RLL, 8'h02, 64'h0000a1f812345678, 1'b0},
    '{dd_pkg::DD_CMD_FORMAT, dd_pkg::DD_MODE_RLL, 8'h02, 64'h0000a1fe12345678, 1'b0}};
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic read_clock_in = 1'b0;
  logic cmd_write = 1'b0;
  logic [1:0] cmd_code = 2'h0;
  logic [1:0] mode = 2'h0;
  logic hard_sector = 1'b0;
  dd_pkg::dd_fmt_cfg_t fmt_cfg = '0;
  dd_pkg::dd_id_t target_id = 32'h12345678;
  logic [7:0] wr_byte = 8'h5a;
  logic wr_byte_valid = 1'b1;
  logic wr_byte_ready;
  logic write_fault_in = 1'b0;
  logic sector_marker_in = 1'b0;
  logic read_data_in;
  logic disk_write_data;
  logic late_clk_out;
  logic early_ame_out;
  logic write_gate_out;
  logic read_gate_out;
  dd_pkg::dd_status_t status;
  logic [63:0] rd_pat = 64'h0;
  logic [63:0] wr_cap;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;
  int ready_cnt = 0;

  always #12.5 clock = ~clock;
  initial begin
    #7;
    forever #15 read_clock_in = ~read_clock_in;
  end

  dd_drive_data_if #(.SEARCH_TIMEOUT_CYCLES(2000)) dut (.clock, .rst, .read_clock_in, .cmd_write, .cmd_code,
    .mode, .hard_sector, .fmt_cfg, .target_id, .wr_byte, .wr_byte_valid, .wr_byte_ready, .write_fault_in,
    .sector_marker_in, .read_data_in, .disk_write_data, .late_clk_out, .early_ame_out, .write_gate_out,
    .read_gate_out, .status);
  dd_drive_model u_drive (.clock, .rst, .read_clock_in, .disk_write_data, .write_gate_out, .read_gate_out,
    .rd_pat, .read_data_in, .wr_cap);

  task automatic print_verdict();
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Issue a command; hold off (longer with sect), then pulse the sector input
  task automatic run_cmd(input logic [1:0] code, input logic sect);
    int n;
    @(posedge clock);
    cmd_write <= 1'b1;
    cmd_code <= code;
    @(posedge clock);
    cmd_write <= 1'b0;
    repeat (sect ? 30 : 10) @(posedge clock);
    if (sect) begin
      #1;
      chk(64'(read_gate_out), 64'h0);
    end
    // Sector start when hard, data run while searching when soft
    @(posedge clock);
    sector_marker_in <= 1'b1;
    repeat (4) @(posedge clock);
    sector_marker_in <= 1'b0;
    n = 0;
    do begin
      @(posedge clock);
      #1;
      n++;
    end while (status.done !== 1'b1 && n < 20000);
    chk(64'(n < 20000), 64'h1);
  endtask

  always @(posedge clock) begin
    cycles++;
    if (wr_byte_ready === 1'b1) begin
      ready_cnt++;
    end
    if (cycles == 60000) begin
      error_cnt++;
      print_verdict();
    end
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    int base;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    chk(64'({disk_write_data, late_clk_out, early_ame_out, write_gate_out, read_gate_out, status}), 64'h0);
    foreach (ROWS[i]) begin
      @(posedge clock);
      mode <= ROWS[i].mode;
      rd_pat <= ROWS[i].pat;
      fmt_cfg <= '{8'h02, ROWS[i].pre, 8'h03, 8'h4e, 4'h1, 4'h1};
      base = ready_cnt;
      run_cmd(ROWS[i].code, 1'b0);
      if (ROWS[i].code != dd_pkg::DD_CMD_READ_ID) begin
        chk(wr_cap, ROWS[i].pat);
        chk(64'(ready_cnt - base), 64'(dd_pkg::DD_SECTOR_BYTES));
      end else begin
        chk(64'(status.id_match), 64'(ROWS[i].match));
      end
    end
    // Hard sector: search waits for the sector pulse
    @(posedge clock);
    hard_sector <= 1'b1;
    rd_pat <= 64'h0000a1fe12345678;
    run_cmd(dd_pkg::DD_CMD_READ_ID, 1'b1);
    chk(64'(status.id_match), 64'h1);
    // NRZ write starved of data, refused command, then fault
    @(posedge clock);
    hard_sector <= 1'b0;
    mode <= dd_pkg::DD_MODE_NRZ;
    wr_byte_valid <= 1'b0;
    fork
      run_cmd(dd_pkg::DD_CMD_WRITE, 1'b0);
      begin
        repeat (100) @(posedge clock);
        cmd_code <= dd_pkg::DD_CMD_READ_ID;
        cmd_write <= 1'b1;
        @(posedge clock);
        cmd_write <= 1'b0;
        repeat (100) @(posedge clock);
        write_fault_in <= 1'b1;
      end
    join
    chk(64'({status.fault, status.underrun, write_gate_out}), 64'h6);
    repeat (3) @(posedge clock);
    write_fault_in <= 1'b0;
    #1;
    chk(64'({status.busy, read_gate_out}), 64'h0);
    // MFM read: data cells split from clock cells, zero tail as last ID bytes
    @(posedge clock);
    mode <= dd_pkg::DD_MODE_MFM;
    target_id <= 32'h12340000;
    rd_pat <= 64'h44895554a924a512;
    run_cmd(dd_pkg::DD_CMD_READ_ID, 1'b0);
    chk(64'(status.id_match), 64'h1);
    print_verdict();
  end
endmodule
